// *** rtl/dmc_pkg.sv ***
// Package: constants for the DMA channel mode control block
package dmc_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int          NUM_CH_DEF   = 6;
   localparam int          CODE_W       = 3;
   localparam int          SEL_W        = 5;
   localparam int          NUM_SRC      = 32;
   localparam int          BURST_W      = 5;
   localparam int          XFER_W       = 16;
   localparam int          ADDR_W       = 8;

   // ------------------------------------------------------------
   // Register byte offsets and bank numbers
   // ------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_PRIO_STAT = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
   localparam logic [7:0]  OFS_RUN_CMD   = 8'h10;
   localparam logic [2:0]  BANK_MODE     = 3'h1;
   localparam logic [2:0]  BANK_SIZE     = 3'h2;

   // ------------------------------------------------------------
   // Mode register fields
   // ------------------------------------------------------------
   localparam int          MODE_IRQ_EN      = 15;
   localparam int          MODE_WIDE        = 14;
   localparam int          MODE_SYNC_DST    = 13;
   localparam int          MODE_SYNC_EN     = 12;
   localparam int          MODE_CONT        = 11;
   localparam int          MODE_BURST_CHAIN_MODE     = 10;
   localparam int          MODE_IRQ_AT_END  = 9;
   localparam int          MODE_TRIG_EN     = 8;
   localparam int          MODE_OVF_EN      = 7;
   localparam logic [15:0] MODE_WR_MASK     = 16'hFF9F;
   localparam logic [15:0] MODE_RST         = 16'h0000;
   localparam logic [4:0]  SEL_NONE         = 5'h00;
   localparam logic [4:0]  SEL_CONVERTER    = 5'h01;

   // ------------------------------------------------------------
   // Other field positions
   // ------------------------------------------------------------
   localparam int          PRIO_SHADOW_LSB  = 4;
   localparam int          CTRL_CH1_HIGH    = 0;
   localparam int          RUN_HALT_LSB     = 8;
   localparam int          RUN_FORCE_LSB    = 16;
   localparam int          STAT_OVF_LSB     = 8;
   localparam int          SIZE_XFER_LSB    = 16;
   localparam logic [2:0]  CODE_NONE        = 3'h0;

   typedef enum logic {ENG_IDLE, ENG_BURST} dmc_eng_type;
endpackage : dmc_pkg

// *** rtl/dmc_chan_if.sv ***
// Interface: signals between the engine and one channel controller
`timescale 1ns/10ps
`default_nettype none
interface dmc_chan_if;
   logic [15:0] mode;
   logic [15:0] xferBursts;
   logic        runCmd;
   logic        haltCmd;
   logic        forceCmd;
   logic        grant;
   logic        burstDone;
   logic        ready;
   logic        running;
   logic        pending;
   logic        chanIrq;
   logic        ovfEvt;
   logic        syncSrc;
   logic        syncDst;

   modport chan (input mode, xferBursts, runCmd, haltCmd, forceCmd, grant, burstDone,
                 output ready, running, pending, chanIrq, ovfEvt, syncSrc, syncDst);
   modport eng  (output mode, xferBursts, runCmd, haltCmd, forceCmd, grant, burstDone,
                 input ready, running, pending, chanIrq, ovfEvt, syncSrc, syncDst);
endinterface : dmc_chan_if
`default_nettype wire

// *** rtl/dmc_chan_ctrl.sv ***
// Module: per-channel trigger, mode and interrupt sequencing
`timescale 1ns/10ps
`default_nettype none
module dmc_chan_ctrl
   import dmc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic [NUM_SRC-1:0] trigSrc,
   input  wire logic               convSync,
   dmc_chan_if.chan                ch
);
   logic [SEL_W-1:0]  trigSel;
   logic              newTrig;
   logic              syncHit;
   logic              xferEnd;
   logic              pending_r;
   logic              running_r;
   logic              chain_r;
   logic              fresh_r;
   logic [XFER_W-1:0] remain_r;
   logic              chanIrq_r;
   logic              ovf_r;
   logic              syncSrc_r;
   logic              syncDst_r;

   assign trigSel = ch.mode[SEL_W-1:0];
   // Neither the peripheral nor a software force starts a burst unless enabled
   assign newTrig = ch.mode[MODE_TRIG_EN] &
                    (((trigSel != SEL_NONE) & trigSrc[trigSel]) | ch.forceCmd);
   assign syncHit = ch.mode[MODE_SYNC_EN] & (trigSel == SEL_CONVERTER) & convSync;
   assign xferEnd = ch.burstDone & (remain_r == '0);

   // ------------------------------------------------------------
   // Latched trigger and overflow
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pending_r <= 1'b0;
         ovf_r     <= 1'b0;
      end else begin
         ovf_r <= newTrig & pending_r & ~ch.grant & ch.mode[MODE_OVF_EN];
         if (newTrig)
            pending_r <= 1'b1;
         else if (ch.grant | ch.haltCmd)
            pending_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Transfer sequencing
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         running_r <= 1'b0;
         remain_r  <= '0;
         chain_r   <= 1'b0;
         fresh_r   <= 1'b0;
      end else begin
         if (ch.haltCmd) begin
            running_r <= 1'b0;
            chain_r   <= 1'b0;
         end else if (ch.runCmd) begin
            running_r <= 1'b1;
            remain_r  <= ch.xferBursts;
            chain_r   <= 1'b0;
            fresh_r   <= 1'b1;
         end else begin
            if (ch.grant) begin
               fresh_r <= 1'b0;
               if (ch.mode[MODE_BURST_CHAIN_MODE])
                  chain_r <= 1'b1;
            end
            if (xferEnd) begin
               chain_r <= 1'b0;
               if (ch.mode[MODE_CONT]) begin
                  remain_r <= ch.xferBursts;
                  fresh_r  <= 1'b1;
               end else begin
                  running_r <= 1'b0;
               end
            end else if (ch.burstDone) begin
               remain_r <= remain_r - 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Channel interrupt and sync pulses
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chanIrq_r <= 1'b0;
         syncSrc_r <= 1'b0;
         syncDst_r <= 1'b0;
      end else begin
         chanIrq_r <= ch.mode[MODE_IRQ_EN] &
                      ((ch.grant & fresh_r & ~ch.mode[MODE_IRQ_AT_END]) |
                       (xferEnd & ch.mode[MODE_IRQ_AT_END]));
         syncSrc_r <= syncHit & ~ch.mode[MODE_SYNC_DST];
         syncDst_r <= syncHit & ch.mode[MODE_SYNC_DST];
      end
   end

   assign ch.ready   = running_r & (pending_r | chain_r);
   assign ch.running = running_r;
   assign ch.pending = pending_r;
   assign ch.chanIrq = chanIrq_r;
   assign ch.ovfEvt  = ovf_r;
   assign ch.syncSrc = syncSrc_r;
   assign ch.syncDst = syncDst_r;
endmodule : dmc_chan_ctrl
`default_nettype wire

// *** rtl/dmc_mode_ctrl.sv ***
// Module: six-channel DMA mode control, burst engine and register slave
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl
   import dmc_pkg::*;
#(
   parameter int NUM_CH = NUM_CH_DEF
)(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic [ADDR_W-1:0]  avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic [NUM_SRC-1:0] trigSrc,
   input  wire logic               convSync,
   output logic                    wordStrobe,
   output logic                    wordWide,
   output logic      [CODE_W-1:0]  wordChanCode,
   output logic      [NUM_CH-1:0]  chanIrq,
   output logic      [NUM_CH-1:0]  syncSrcWrap,
   output logic      [NUM_CH-1:0]  syncDstWrap,
   output logic                    irq
);
   if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_num_ch
      $error("NUM_CH must lie between 1 and 6");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   dmc_chan_if                chIf [NUM_CH] ();
   logic        [15:0]        mode_r [NUM_CH];
   logic        [31:0]        size_r [NUM_CH];
   logic                      ch1High_r;
   logic        [31:0]        irqStat_r;
   logic        [31:0]        irqMask_r;
   logic                      answer_r;
   logic        [31:0]        readdata_r;
   logic        [NUM_CH-1:0]  runCmd_r;
   logic        [NUM_CH-1:0]  haltCmd_r;
   logic        [NUM_CH-1:0]  forceCmd_r;
   logic        [NUM_CH-1:0]  readyVec;
   logic        [NUM_CH-1:0]  runningVec;
   logic        [NUM_CH-1:0]  chIrqVec;
   logic        [NUM_CH-1:0]  ovfVec;
   logic        [NUM_CH-1:0]  grantVec;
   logic        [NUM_CH-1:0]  burstDoneVec;
   dmc_eng_type               engState_r;
   logic        [CODE_W-1:0]  activeCode_r;
   logic        [CODE_W-1:0]  shadowCode_r;
   logic        [CODE_W-1:0]  lastCode_r;
   logic        [BURST_W-1:0] wordCnt_r;
   logic        [BURST_W-1:0] savedCnt_r;
   logic                      wordStrobe_r;
   logic                      wordWide_r;
   logic        [CODE_W-1:0]  wordChanCode_r;
   logic                      accWrite;
   logic                      accRead;
   logic                      bankHit;
   logic        [2:0]         bankIdx;
   logic        [CODE_W-1:0]  pickCode;
   logic                      preempt;
   logic                      lastWord;
   logic        [CODE_W-1:0]  nextCode_nxt;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge_be(input logic [31:0] oldVal, input logic [31:0] newVal,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (be[b])
            res[8*b +: 8] = newVal[8*b +: 8];
      end
      return res;
   endfunction : merge_be

   function automatic logic [CODE_W-1:0] code_of(input int idx);
      return CODE_W'(idx + 1);
   endfunction : code_of

   function automatic int idx_of(input logic [CODE_W-1:0] code);
      return (code == CODE_NONE) ? 0 : int'(code) - 1;
   endfunction : idx_of

   // Round-robin search starting after the last served channel
   function automatic logic [CODE_W-1:0] pick_rr(input logic [NUM_CH-1:0] rdy,
                                                  input logic [CODE_W-1:0] last);
      logic [CODE_W-1:0] res;
      int                cand;
      res = CODE_NONE;
      for (int k = NUM_CH; k >= 1; k--) begin
         cand = (idx_of(last) + k) % NUM_CH;
         if (rdy[cand])
            res = code_of(cand);
      end
      return res;
   endfunction : pick_rr

   // ------------------------------------------------------------
   // Channel controllers
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign chIf[i].mode       = mode_r[i];
      assign chIf[i].xferBursts = size_r[i][SIZE_XFER_LSB +: XFER_W];
      assign chIf[i].runCmd     = runCmd_r[i];
      assign chIf[i].haltCmd    = haltCmd_r[i];
      assign chIf[i].forceCmd   = forceCmd_r[i];
      assign chIf[i].grant      = grantVec[i];
      assign chIf[i].burstDone  = burstDoneVec[i];
      assign readyVec[i]        = chIf[i].ready;
      assign runningVec[i]      = chIf[i].running;
      assign chIrqVec[i]        = chIf[i].chanIrq;
      assign ovfVec[i]          = chIf[i].ovfEvt;
      assign syncSrcWrap[i]     = chIf[i].syncSrc;
      assign syncDstWrap[i]     = chIf[i].syncDst;

      dmc_chan_ctrl u_chan (
         .clk      (clk),
         .rst_b    (rst_b),
         .trigSrc  (trigSrc),
         .convSync (convSync),
         .ch       (chIf[i])
      );
   end

   // ------------------------------------------------------------
   // Avalon slave: one wait cycle, then the answer
   // ------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~answer_r;
   assign accWrite        = avs_write & answer_r;
   assign accRead         = avs_read & ~answer_r;
   assign bankIdx         = avs_address[4:2];
   assign bankHit         = (32'(bankIdx) < NUM_CH);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         answer_r <= 1'b0;
      else
         answer_r <= (avs_read | avs_write) & ~answer_r;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readdata_r <= '0;
      end else if (accRead) begin
         readdata_r <= '0;
         if (avs_address[7:5] == BANK_MODE && bankHit)
            readdata_r <= {16'h0000, mode_r[bankIdx]};
         else if (avs_address[7:5] == BANK_SIZE && bankHit)
            readdata_r <= size_r[bankIdx];
         else begin
            case (avs_address)
               OFS_CTRL:      readdata_r <= 32'(ch1High_r);
               OFS_PRIO_STAT: readdata_r <= 32'({shadowCode_r, 1'b0, activeCode_r});
               OFS_IRQ_STAT:  readdata_r <= irqStat_r;
               OFS_IRQ_MASK:  readdata_r <= irqMask_r;
               OFS_RUN_CMD:   readdata_r <= 32'(runningVec);
               default:       readdata_r <= '0;
            endcase
         end
      end
   end
   assign avs_readdata = readdata_r;

   // ------------------------------------------------------------
   // Mode, size and control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_r[c] <= MODE_RST;
            size_r[c] <= '0;
         end
         ch1High_r <= 1'b0;
         irqMask_r <= '0;
      end else if (accWrite) begin
         // Reserved mode bits are masked so they always read zero
         if (avs_address[7:5] == BANK_MODE && bankHit)
            mode_r[bankIdx] <= 16'(merge_be({16'h0000, mode_r[bankIdx]}, avs_writedata,
                                            avs_byteenable)) & MODE_WR_MASK;
         else if (avs_address[7:5] == BANK_SIZE && bankHit)
            size_r[bankIdx] <= merge_be(size_r[bankIdx], avs_writedata, avs_byteenable);
         else if (avs_address == OFS_CTRL)
            ch1High_r <= 1'(merge_be(32'(ch1High_r), avs_writedata, avs_byteenable) >> CTRL_CH1_HIGH);
         else if (avs_address == OFS_IRQ_MASK)
            irqMask_r <= merge_be(irqMask_r, avs_writedata, avs_byteenable);
      end
   end

   // Run, halt and force commands are one-cycle pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         runCmd_r   <= '0;
         haltCmd_r  <= '0;
         forceCmd_r <= '0;
      end else begin
         runCmd_r   <= '0;
         haltCmd_r  <= '0;
         forceCmd_r <= '0;
         if (accWrite && avs_address == OFS_RUN_CMD) begin
            runCmd_r   <= avs_writedata[NUM_CH-1:0] & {NUM_CH{avs_byteenable[0]}};
            haltCmd_r  <= avs_writedata[RUN_HALT_LSB +: NUM_CH] & {NUM_CH{avs_byteenable[1]}};
            forceCmd_r <= avs_writedata[RUN_FORCE_LSB +: NUM_CH] & {NUM_CH{avs_byteenable[2]}};
         end
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_r <= '0;
      end else begin
         for (int b = 0; b < 32; b++) begin
            if (accWrite && avs_address == OFS_IRQ_STAT && avs_byteenable[b/8] && avs_writedata[b])
               irqStat_r[b] <= 1'b0;
         end
         for (int c = 0; c < NUM_CH; c++) begin
            if (chIrqVec[c])
               irqStat_r[c] <= 1'b1;
            if (ovfVec[c])
               irqStat_r[STAT_OVF_LSB + c] <= 1'b1;
         end
      end
   end

   assign irq     = |(irqStat_r & irqMask_r);
   assign chanIrq = chIrqVec;

   // ------------------------------------------------------------
   // Burst engine
   // ------------------------------------------------------------
   assign pickCode = (ch1High_r && readyVec[0]) ? code_of(0) : pick_rr(readyVec, lastCode_r);
   // Channel one may cut into another channel's burst only once at a time
   assign preempt  = (engState_r == ENG_BURST) && ch1High_r && readyVec[0] &&
                     (activeCode_r != code_of(0)) && (shadowCode_r == CODE_NONE);
   assign lastWord = (engState_r == ENG_BURST) && !preempt && (wordCnt_r == '0);

   always_comb begin
      grantVec     = '0;
      burstDoneVec = '0;
      if (engState_r == ENG_IDLE && pickCode != CODE_NONE)
         grantVec[idx_of(pickCode)] = 1'b1;
      else if (preempt)
         grantVec[0] = 1'b1;
      if (lastWord)
         burstDoneVec[idx_of(activeCode_r)] = 1'b1;
   end

   // Resume the interrupted channel when channel one ends its burst
   always_comb begin
      nextCode_nxt = CODE_NONE;
      if (activeCode_r == code_of(0))
         nextCode_nxt = shadowCode_r;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         engState_r   <= ENG_IDLE;
         activeCode_r <= CODE_NONE;
         shadowCode_r <= CODE_NONE;
         lastCode_r   <= CODE_NONE;
         wordCnt_r    <= '0;
         savedCnt_r   <= '0;
      end else begin
         case (engState_r)
            ENG_IDLE: begin
               if (pickCode != CODE_NONE) begin
                  engState_r   <= ENG_BURST;
                  activeCode_r <= pickCode;
                  lastCode_r   <= pickCode;
                  wordCnt_r    <= size_r[idx_of(pickCode)][BURST_W-1:0];
               end
            end
            ENG_BURST: begin
               if (preempt) begin
                  shadowCode_r <= activeCode_r;
                  savedCnt_r   <= wordCnt_r;
                  activeCode_r <= code_of(0);
                  wordCnt_r    <= size_r[0][BURST_W-1:0];
               end else if (lastWord) begin
                  activeCode_r <= nextCode_nxt;
                  if (nextCode_nxt != CODE_NONE) begin
                     shadowCode_r <= CODE_NONE;
                     wordCnt_r    <= savedCnt_r;
                  end else begin
                     engState_r <= ENG_IDLE;
                  end
               end else begin
                  wordCnt_r <= wordCnt_r - 1'b1;
               end
            end
            default: engState_r <= ENG_IDLE;
         endcase
      end
   end

   // One word per burst cycle except the preempting cycle; width follows the active channel
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wordStrobe_r   <= 1'b0;
         wordWide_r     <= 1'b0;
         wordChanCode_r <= CODE_NONE;
      end else begin
         wordStrobe_r   <= (engState_r == ENG_BURST) && !preempt;
         wordWide_r     <= mode_r[idx_of(activeCode_r)][MODE_WIDE];
         wordChanCode_r <= activeCode_r;
      end
   end

   assign wordStrobe   = wordStrobe_r;
   assign wordWide     = wordWide_r;
   assign wordChanCode = wordChanCode_r;
endmodule : dmc_mode_ctrl
`default_nettype wire

// *** testbench/dmc_mode_ctrl_properties.sv ***
// Checker: bus and output timing of the mode control block
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl_chk
   import dmc_pkg::*;
#(parameter int NUM_CH = NUM_CH_DEF)(
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              convSync,
   input wire logic              wordStrobe,
   input wire logic [CODE_W-1:0] wordChanCode,
   input wire logic [NUM_CH-1:0] chanIrq,
   input wire logic [NUM_CH-1:0] syncSrcWrap,
   input wire logic [NUM_CH-1:0] syncDstWrap
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   chk_wait_one_cycle: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait not one cycle");
   chk_wait_idle: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
      else $error("wait without request");
   chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   chk_word_code: assert property (wordStrobe |-> wordChanCode inside {[3'h1:3'h6]})
      else $error("bad channel code");
   chk_sync_excl: assert property ((syncSrcWrap & syncDstWrap) == '0)
      else $error("sync to both counters");
   chk_sync_pulse: assert property (|syncSrcWrap && !convSync |=> syncSrcWrap == '0)
      else $error("sync pulse too long");
   chk_sync_cause: assert property (|(syncSrcWrap | syncDstWrap) |-> $past(convSync) || $past(convSync, 2))
      else $error("sync without cause");
   chk_irq_pulse: assert property (|chanIrq |=> (chanIrq & $past(chanIrq)) == '0)
      else $error("channel irq too long");
endmodule : dmc_mode_ctrl_chk
bind dmc_mode_ctrl dmc_mode_ctrl_chk #(.NUM_CH(NUM_CH)) chk_inst(.clk, .rst_b, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .convSync, .wordStrobe, .wordChanCode, .chanIrq, .syncSrcWrap, .syncDstWrap);
`default_nettype wire

// *** testbench/dmc_event_model.sv ***
// Model of the peripheral event sources
`timescale 1ns/10ps
`default_nettype none
module dmc_event_model
   import dmc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               fire,
   input  wire logic [SEL_W-1:0]   sel,
   output logic      [NUM_SRC-1:0] trigSrc,
   output logic                    convSync
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trigSrc <= '0;
         convSync <= 1'b0;
      end else begin
         trigSrc <= fire ? NUM_SRC'(1) << sel : '0;
         convSync <= fire && sel == SEL_CONVERTER;
      end
   end
endmodule : dmc_event_model
`default_nettype wire

// *** testbench/tb_dmc_mode_ctrl.sv ***
// Testbench of the DMA channel mode control block
`timescale 1ns/10ps
`default_nettype none
module tb_dmc_mode_ctrl
   import dmc_pkg::*;
;
   logic clk = 0, rst_b = 0, rd = 0, wr = 0, fire = 0, waitReq, strobe, wide, conv, irq;
   logic [7:0] adr = '0;
   logic [31:0] wd = '0, rdat, q;
   logic [4:0] sel = '0;
   logic [15:0] rv;
   logic [2:0] code;
   logic [5:0] chIrq, sSrc, sDst;
   logic [NUM_SRC-1:0] trig;
   int n_errors = 0, checks = 0, nStr, nWide, nIrq, nSync;
   always #10 clk = ~clk;
   dmc_mode_ctrl dmc_mode_ctrl_inst(.clk, .rst_b, .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(waitReq), .trigSrc(trig),
      .convSync(conv), .wordStrobe(strobe), .wordWide(wide), .wordChanCode(code), .chanIrq(chIrq),
      .syncSrcWrap(sSrc), .syncDstWrap(sDst), .irq);
   dmc_event_model dmc_event_model_inst(.clk, .rst_b, .fire, .sel, .trigSrc(trig), .convSync(conv));
   always @(posedge clk) begin
      nStr += strobe;
      nWide += strobe & wide;
      nIrq += chIrq[0];
      nSync += sSrc[0];
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         t++;
      end while (waitReq !== 1'b0 && t < 50);
      q = rdat;
      rd <= 0;
      wr <= 0;
      if (t >= 50) begin
         n_errors++;
         give_verdict();
      end
   endtask : bus
   task automatic pulse(input logic [4:0] s);
      sel <= s;
      fire <= 1;
      @(posedge clk);
      fire <= 0;
   endtask : pulse
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   function automatic int expWords(input logic [15:0] m, input int n, input int nt);
      return m[MODE_TRIG_EN] ? (m[MODE_BURST_CHAIN_MODE] ? 2 : nt) * (n + 1) : 0;
   endfunction : expWords
   task automatic scen(input logic [15:0] m, input int nt);
      int n;
      n = $urandom_range(3);
      if (m[4:0] == 0) m[4:0] = 5'($urandom_range(31, 2));
      bus(1, OFS_RUN_CMD, 32'h3F00);
      bus(1, 8'h20, {16'h0, m});
      bus(1, 8'h40, {16'h1, 16'(n)});
      bus(1, OFS_RUN_CMD, 32'h1);
      {nStr, nWide, nIrq, nSync} = '0;
      pulse(m[4:0]);
      repeat (40) @(posedge clk);
      if (nt == 2) bus(1, OFS_RUN_CMD, 32'h10000);
      repeat (40) @(posedge clk);
      chk("words", expWords(m, n, nt), nStr);
      chk("wide", m[14] ? expWords(m, n, nt) : 0, nWide);
      chk("chanIrq", m[15] & m[8], nIrq);
      chk("sync", m[12] & (m[4:0] == 1), nSync);
      bus(0, OFS_RUN_CMD, 0);
      chk("running", !m[8] || m[11] || !(m[10] || nt == 2), q[0]);
      bus(1, OFS_IRQ_MASK, 1);
      @(negedge clk);
      chk("irq", m[15] & m[8], irq);
      bus(1, OFS_IRQ_STAT, 32'h3F3F);
      @(negedge clk);
      chk("irq clear", 0, irq);
      bus(1, OFS_IRQ_MASK, 0);
   endtask : scen
   task automatic give_verdict;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(93));
      repeat (4) @(posedge clk);
      rst_b <= 1;
      bus(0, 8'h20, 0);
      chk("mode reset", 0, q);
      bus(0, OFS_PRIO_STAT, 0);
      chk("active idle", 0, q[2:0]);
      rv = 16'($urandom);
      bus(1, 8'h20, {16'h0, rv});
      bus(0, 8'h20, 0);
      chk("mode bits", {16'h0, rv & 16'hFF9F}, q);
      bus(0, 8'hFC, 0);
      chk("unmapped", 0, q);
      scen(16'h8000, 2);
      scen(16'h8100, 2);
      scen(16'hDF01, 1);
      rst_b <= 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      bus(0, 8'h20, 0);
      chk("mode after reset", 0, q);
      bus(1, OFS_CTRL, 1);
      bus(1, 8'h24, 32'h0182);
      bus(1, 8'h44, 32'h1F);
      bus(1, 8'h20, 32'h0103);
      bus(1, 8'h40, 32'h1F);
      bus(1, OFS_RUN_CMD, 32'h3);
      pulse(5'h02);
      repeat (6) @(posedge clk);
      pulse(5'h03);
      repeat (6) @(posedge clk);
      bus(0, OFS_PRIO_STAT, 0);
      chk("preempt status", 32'h21, q);
      repeat (40) @(posedge clk);
      bus(0, OFS_PRIO_STAT, 0);
      chk("resume status", 32'h02, q);
      repeat (20) @(posedge clk);
      sel <= 5'h02;
      fire <= 1;
      repeat (2) @(posedge clk);
      fire <= 0;
      repeat (2) @(posedge clk);
      bus(0, OFS_IRQ_STAT, 0);
      chk("overflow", 32'h200, q);
      scen(16'h3500, 1);
      give_verdict();
   end
endmodule : tb_dmc_mode_ctrl
`default_nettype wire
